/* File: logic/ast_pkg.sv */
// Purpose: Shared constants and types of the protection switching time tester
// Assumes: 125 MHz clock, 32-bit AXI4-Lite register bus
// Notes:   Durations are held in microseconds
package ast_pkg;

   localparam int unsigned CLK_HZ        = 125_000_000;
   localparam int unsigned TICK_US       = 1;
   localparam int unsigned CYC_PER_TICK  = (CLK_HZ / 1_000_000) * TICK_US;
   localparam int unsigned US_PER_MS     = 1000;
   localparam int unsigned THR_SDH_MS    = 10000;
   localparam int unsigned THR_PDH_MS    = 4000;

   localparam int unsigned DUR_W   = 24;
   localparam int unsigned SUM_W   = 32;
   localparam int unsigned CNT_W   = 16;
   localparam int unsigned LOG_AW  = 8;
   localparam int unsigned EVT_W   = 16;
   localparam int unsigned PRE_W   = 7;
   localparam int unsigned DIV_W   = 6;

   localparam logic [DUR_W-1:0] THR_MAX_SDH = DUR_W'(THR_SDH_MS * US_PER_MS);
   localparam logic [DUR_W-1:0] THR_MAX_PDH = DUR_W'(THR_PDH_MS * US_PER_MS);
   localparam logic [DUR_W-1:0] DUR_SAT     = {DUR_W{1'b1}};
   localparam logic [PRE_W-1:0] PRE_LAST    = PRE_W'(CYC_PER_TICK - 1);
   localparam logic [DIV_W-1:0] DIV_STEPS   = DIV_W'(SUM_W);

   // Event indices on the alarm and error vector
   localparam int unsigned EVT_LOS   = 0;
   localparam int unsigned EVT_LSS   = 14;
   localparam int unsigned EVT_TCREI = 15;
   localparam int unsigned REF_ANY   = 16;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_REF      = 8'h04;
   localparam logic [7:0] OFS_EFP      = 8'h08;
   localparam logic [7:0] OFS_THR      = 8'h0C;
   localparam logic [7:0] OFS_KCFG     = 8'h10;
   localparam logic [7:0] OFS_APPLY    = 8'h14;
   localparam logic [7:0] OFS_STATUS   = 8'h18;
   localparam logic [7:0] OFS_COUNT    = 8'h1C;
   localparam logic [7:0] OFS_MIN      = 8'h20;
   localparam logic [7:0] OFS_MAX      = 8'h24;
   localparam logic [7:0] OFS_AVG      = 8'h28;
   localparam logic [7:0] OFS_RXK      = 8'h2C;
   localparam logic [7:0] OFS_LOG_IDX  = 8'h30;
   localparam logic [7:0] OFS_LOG_DATA = 8'h34;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h38;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h3C;

   // Control fields
   localparam int unsigned CTRL_RUN  = 0;
   localparam int unsigned CTRL_SDH  = 1;
   localparam int unsigned CTRL_ELEC = 2;
   localparam int unsigned CTRL_CLR  = 3;

   // Status fields
   localparam int unsigned ST_FAIL  = 0;
   localparam int unsigned ST_BUSY  = 1;
   localparam int unsigned ST_AVGOK = 2;
   localparam int unsigned ST_APPL  = 3;

   // Interrupt bits
   localparam int unsigned IRQ_DONE = 0;
   localparam int unsigned IRQ_FAIL = 1;
   localparam int unsigned IRQ_KCHG = 2;
   localparam int unsigned IRQ_W    = 3;

   // Protection request codes, K1 bits 1 to 4
   localparam logic [3:0] REQ_LOCKOUT = 4'hF;
   localparam logic [3:0] REQ_FORCED  = 4'hE;
   localparam logic [3:0] REQ_SF_HIGH = 4'hD;
   localparam logic [3:0] REQ_SF_LOW  = 4'hC;
   localparam logic [3:0] REQ_SD_HIGH = 4'hB;
   localparam logic [3:0] REQ_MANUAL  = 4'h8;
   localparam logic [3:0] REQ_NONE    = 4'h0;
   localparam logic [2:0] K2_LIN_MODE = 3'h5;
   localparam logic [7:0] K_IDLE      = 8'h00;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [2:0] mode;
      logic       path_arch;
      logic       ring;
      logic [3:0] node;
      logic [3:0] chan;
      logic [3:0] req;
   } ast_kcfg_t;

   localparam int unsigned KCFG_W = $bits(ast_kcfg_t);

   typedef struct packed {
      logic [DUR_W-1:0] min_us;
      logic [DUR_W-1:0] max_us;
      logic [SUM_W-1:0] sum_us;
      logic [CNT_W-1:0] cnt;
   } ast_stats_t;

endpackage : ast_pkg

/* File: logic/ast_dur_mem.sv */
// Purpose: Store of per-occurrence durations
// Assumes: One write and one read port on the same clock
// Notes:   Read data come out of a register
`timescale 1ns/1ps
`default_nettype none
module ast_dur_mem
   import ast_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              wr_en_i,
   input  wire logic [LOG_AW-1:0] wr_addr_i,
   input  wire logic [DUR_W-1:0]  wr_data_i,
   input  wire logic [LOG_AW-1:0] rd_addr_i,
   output logic      [DUR_W-1:0]  rd_data_o
);
   logic [DUR_W-1:0] mem [0:(1<<LOG_AW)-1];

   always_ff @(posedge ref_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end
endmodule : ast_dur_mem
`default_nettype wire

/* File: logic/ast_switch_tester.sv */
// Purpose: Protection switching time tester with K1/K2 insertion and decode
// Assumes: Alarm vector, frame pulse and received K bytes from same-clock framer
// Notes:   Registers over AXI4-Lite; durations in microseconds
// Contract
// - SDH: decode K1/K2, time reference alarm durations
// - PDH: time reference events and count them
// - Any errors: every selectable event triggers
// - SDH: LSS and TC-REI never trigger
// - No LOS reference on electrical SDH
// - SDH: error-free period ends a measurement
// - Threshold limited to 10000 or 4000 ms
// - Threshold decides pass or fail verdict
// - Each occurrence duration is stored individually; the log holds 256 entries and then wraps over the oldest
// - Report min, max, average, threshold, count
// - Channel number into K1 bits 5-8
// - Node number into K2 bits 1-4
// - Operator chooses K1 request type
// - Transmit request only after apply command
// - Ring short/long, linear 1+1 or 1:n
`timescale 1ns/1ps
`default_nettype none
module ast_switch_tester
   import ast_pkg::*;
(
   input  wire logic             ref_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic [EVT_W-1:0] evt_i,
   input  wire logic             frame_i,
   input  wire logic [7:0]       rx_k1_i,
   input  wire logic [7:0]       rx_k2_i,
   output logic      [7:0]       tx_k1_o,
   output logic      [7:0]       tx_k2_o,
   output logic                  irq_o,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [7:0]       s_axi_awaddr,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   output logic      [1:0]       s_axi_bresp,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   input  wire logic [7:0]       s_axi_araddr,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   output logic      [31:0]      s_axi_rdata,
   output logic      [1:0]       s_axi_rresp
);
   import ast_pkg::*;
   typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_QUIET, ST_DONE} ast_meas_t;
   logic [3:0]         ctrl, w_strb;
   logic [REF_ANY:0]   ref_sel;
   logic [DUR_W-1:0]   efp_us, thr_us, avg_us, dur, end_dur, quiet, log_rd;
   ast_kcfg_t          kcfg;
   logic               apply_pend, applied, fail, avg_ok, tick, trig, done_evt, fail_evt;
   logic               kchg_evt, wr_go, wr_hit, rd_hit;
   logic [IRQ_W-1:0]   irq_stat, irq_mask;
   logic [LOG_AW-1:0]  log_idx;
   ast_stats_t         stats;
   logic [7:0]         rx_k1, rx_k2, aw_addr;
   ast_meas_t          state;
   logic [PRE_W-1:0]   pre;
   logic [EVT_W-1:0]   eff_mask;
   logic [DIV_W-1:0]   div_cnt;
   logic [SUM_W-1:0]   div_num, div_quo;
   logic [SUM_W:0]     div_rem;
   logic [CNT_W-1:0]   div_den;
   logic [31:0]        w_data, rd_val;
   // Clamp threshold to line limit
   function automatic logic [DUR_W-1:0] ast_limit(input logic [31:0] val, input logic sdh);
      logic [DUR_W-1:0] lim;
      lim = sdh ? THR_MAX_SDH : THR_MAX_PDH;
      ast_limit = (val > {8'h00, lim}) ? lim : val[DUR_W-1:0];
   endfunction : ast_limit
   // Mapped register offset
   function automatic logic ast_mapped(input logic [7:0] a);
      ast_mapped = (a[1:0] == 2'h0) && (a <= OFS_IRQ_MASK);
   endfunction : ast_mapped
   ////////////////////////////////////////////////////////////////////////////
   // Register bus: write channel
   assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_hit = wr_go && ast_mapped(aw_addr);
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= ast_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl     <= 4'h0;
         ref_sel  <= '0;
         efp_us   <= '0;
         thr_us   <= '0;
         kcfg     <= '0;
         irq_mask <= '0;
         log_idx  <= '0;
      end else begin
         ctrl[CTRL_CLR] <= 1'b0;
         if (wr_hit && w_strb == 4'hF) begin
            unique case (aw_addr)
               OFS_CTRL:     ctrl     <= w_data[3:0];
               OFS_REF:      ref_sel  <= w_data[REF_ANY:0];
               OFS_EFP:      efp_us   <= w_data[DUR_W-1:0];
               OFS_THR:      thr_us   <= ast_limit(w_data, ctrl[CTRL_SDH]);
               OFS_KCFG:     kcfg     <= w_data[KCFG_W-1:0];
               OFS_IRQ_MASK: irq_mask <= w_data[IRQ_W-1:0];
               OFS_LOG_IDX:  log_idx  <= w_data[LOG_AW-1:0];
               default:      ;
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Register bus: read channel
   always_comb begin
      unique case (s_axi_araddr)
         OFS_CTRL:     rd_val = {28'h0, 1'b0, ctrl[2:0]};
         OFS_REF:      rd_val = 32'(ref_sel);
         OFS_EFP:      rd_val = 32'(efp_us);
         OFS_THR:      rd_val = 32'(thr_us);
         OFS_KCFG:     rd_val = 32'(kcfg);
         OFS_APPLY:    rd_val = {30'h0, apply_pend, applied};
         OFS_STATUS:   rd_val = {28'h0, applied, avg_ok, (state != ST_IDLE), fail};
         OFS_COUNT:    rd_val = 32'(stats.cnt);
         OFS_MIN:      rd_val = 32'(stats.min_us);
         OFS_MAX:      rd_val = 32'(stats.max_us);
         OFS_AVG:      rd_val = 32'(avg_us);
         OFS_RXK:      rd_val = {16'h0, rx_k1, rx_k2};
         OFS_LOG_IDX:  rd_val = 32'(log_idx);
         OFS_LOG_DATA: rd_val = 32'(log_rd);
         OFS_IRQ_STAT: rd_val = 32'(irq_stat);
         OFS_IRQ_MASK: rd_val = 32'(irq_mask);
         default:      rd_val = 32'h0000_0000;
      endcase
   end
   assign rd_hit = ast_mapped(s_axi_araddr);
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Trigger selection
   always_comb begin
      eff_mask = ref_sel[REF_ANY] ? {EVT_W{1'b1}} : ref_sel[EVT_W-1:0];
      if (ctrl[CTRL_SDH]) begin
         eff_mask[EVT_LSS]   = 1'b0;
         eff_mask[EVT_TCREI] = 1'b0;
         if (ctrl[CTRL_ELEC]) begin
            eff_mask[EVT_LOS] = 1'b0;
         end
      end
   end
   assign trig = ctrl[CTRL_RUN] && |(evt_i & eff_mask);
   assign tick = (pre == PRE_LAST);
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pre <= '0;
      end else begin
         pre <= tick ? '0 : pre + PRE_W'(1);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Duration measurement
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state   <= ST_IDLE;
         dur     <= '0;
         end_dur <= '0;
         quiet   <= '0;
      end else begin
         if (tick && dur != DUR_SAT && state != ST_IDLE) begin
            dur <= dur + DUR_W'(1);
         end
         if (tick && quiet != DUR_SAT) begin
            quiet <= quiet + DUR_W'(1);
         end
         unique case (state)
            ST_IDLE: begin
               dur <= '0;
               if (trig) begin
                  state <= ST_ACTIVE;
               end
            end
            ST_ACTIVE: begin
               quiet   <= '0;
               end_dur <= dur;
               if (!trig) begin
                  state <= ctrl[CTRL_SDH] ? ST_QUIET : ST_DONE;
               end
            end
            ST_QUIET: begin
               if (trig) begin
                  state <= ST_ACTIVE;
               end else if (quiet >= efp_us) begin
                  state <= ST_DONE;
               end
            end
            ST_DONE: state <= ST_IDLE;
         endcase
      end
   end
   assign done_evt = (state == ST_DONE);
   assign fail_evt = done_evt && (end_dur > thr_us);
   ////////////////////////////////////////////////////////////////////////////
   // Statistics and verdict
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stats <= '{min_us: DUR_SAT, max_us: '0, sum_us: '0, cnt: '0};
         fail  <= 1'b0;
      end else if (ctrl[CTRL_CLR]) begin
         stats <= '{min_us: DUR_SAT, max_us: '0, sum_us: '0, cnt: '0};
         fail  <= 1'b0;
      end else if (done_evt) begin
         if (end_dur < stats.min_us) begin
            stats.min_us <= end_dur;
         end
         if (end_dur > stats.max_us) begin
            stats.max_us <= end_dur;
         end
         stats.sum_us <= stats.sum_us + SUM_W'(end_dur);
         stats.cnt    <= stats.cnt + CNT_W'(1);
         if (fail_evt) begin
            fail <= 1'b1;
         end
      end
   end
   // Average is sum over count, rerun per occurrence
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_cnt <= '0;
         div_num <= '0;
         div_rem <= '0;
         div_quo <= '0;
         div_den <= '0;
         avg_us  <= '0;
         avg_ok  <= 1'b0;
      end else if (ctrl[CTRL_CLR]) begin
         div_cnt <= '0;
         avg_us  <= '0;
         avg_ok  <= 1'b0;
      end else if (state == ST_IDLE && $past(done_evt)) begin
         div_cnt <= DIV_STEPS;
         div_num <= stats.sum_us;
         div_den <= stats.cnt;
         div_rem <= '0;
         div_quo <= '0;
         avg_ok  <= 1'b0;
      end else if (div_cnt != '0) begin
         div_cnt <= div_cnt - DIV_W'(1);
         div_num <= {div_num[SUM_W-2:0], 1'b0};
         if ({div_rem[SUM_W-1:0], div_num[SUM_W-1]} >= (SUM_W+1)'(div_den)) begin
            div_rem <= {div_rem[SUM_W-1:0], div_num[SUM_W-1]} - (SUM_W+1)'(div_den);
            div_quo <= {div_quo[SUM_W-2:0], 1'b1};
         end else begin
            div_rem <= {div_rem[SUM_W-1:0], div_num[SUM_W-1]};
            div_quo <= {div_quo[SUM_W-2:0], 1'b0};
         end
         if (div_cnt == DIV_W'(1)) avg_ok <= 1'b1;
      end else if (avg_ok) begin
         avg_us <= div_quo[DUR_W-1:0];
      end
   end
   ast_dur_mem u_log (
      .ref_clk_i (ref_clk_i),
      .wr_en_i   (done_evt),
      .wr_addr_i (stats.cnt[LOG_AW-1:0]),
      .wr_data_i (end_dur),
      .rd_addr_i (log_idx),
      .rd_data_o (log_rd)
   );
   ////////////////////////////////////////////////////////////////////////////
   // K1/K2 transmit and receive
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         apply_pend <= 1'b0;
         applied    <= 1'b0;
         tx_k1_o    <= K_IDLE;
         tx_k2_o    <= K_IDLE;
      end else begin
         if (wr_hit && aw_addr == OFS_APPLY && w_data[0]) begin
            apply_pend <= 1'b1;
         end else if (frame_i && apply_pend) begin
            apply_pend <= 1'b0;
         end
         if (frame_i && apply_pend && ctrl[CTRL_SDH]) begin
            applied <= 1'b1;
            tx_k1_o <= {kcfg.req, kcfg.chan};
            tx_k2_o <= {kcfg.node, kcfg.path_arch, kcfg.ring ? kcfg.mode : K2_LIN_MODE};
         end
      end
   end
   assign kchg_evt = frame_i && ctrl[CTRL_SDH] && ({rx_k1_i, rx_k2_i} != {rx_k1, rx_k2});
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_k1 <= K_IDLE;
         rx_k2 <= K_IDLE;
      end else if (kchg_evt) begin
         rx_k1 <= rx_k1_i;
         rx_k2 <= rx_k2_i;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: set wins over write-one clear
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_stat <= '0;
         irq_o    <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~((wr_hit && aw_addr == OFS_IRQ_STAT) ? w_data[IRQ_W-1:0] : '0))
                     | {kchg_evt, fail_evt, done_evt};
         irq_o    <= |(irq_stat & irq_mask);
      end
   end
endmodule : ast_switch_tester
`default_nettype wire

/* File: tb/ast_switch_props.sv */
// Purpose: Port checks of the switch tester
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to the tester top
`timescale 1ns/1ps
`default_nettype none
module ast_switch_props
   import ast_pkg::*;
(
   input wire logic        ref_clk_i,
   input wire logic        rst_b_i,
   input wire logic        frame_i,
   input wire logic [7:0]  tx_k1_o,
   input wire logic [7:0]  tx_k2_o,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   ////////////////////////////////////////////////////////////
   property p_k1_frame; !$stable(tx_k1_o) |-> $past(frame_i); endproperty
   a_k1_frame: assert property (p_k1_frame) else $error("K1 moved off frame");
   property p_k2_frame; !$stable(tx_k2_o) |-> $past(frame_i); endproperty
   a_k2_frame: assert property (p_k2_frame) else $error("K2 moved off frame");
   property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
   a_b_lat: assert property (p_b_lat) else $error("Write response late");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("Write response dropped");
   property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_aw_block: assert property (p_aw_block) else $error("Write taken during response");
   property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_lat: assert property (p_r_lat) else $error("Read data late");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("Read data dropped");
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("Read taken during response");
   property p_rd_err; s_axi_arvalid && s_axi_arready && (s_axi_araddr > OFS_IRQ_MASK || s_axi_araddr[1:0] != 2'h0)
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
   a_rd_err: assert property (p_rd_err) else $error("Unmapped read not refused");
endmodule : ast_switch_props
bind ast_switch_tester ast_switch_props u_ast_switch_props (.*);
`default_nettype wire

/* File: tb/ast_ne_model.sv */
// Purpose: Far-end network element: frame marker and received K bytes
// Assumes: Same clock as the tester
// Notes:   K bytes only change with a frame marker
`timescale 1ns/1ps
`default_nettype none
module ast_ne_model #(
   parameter int FRAME_CYC = 125
) (
   input  wire logic       ref_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic [7:0] k1_i,
   input  wire logic [7:0] k2_i,
   output logic            frame_o,
   output logic      [7:0] rx_k1_o,
   output logic      [7:0] rx_k2_o
);
   int cnt;
   // Frame marker every FRAME_CYC cycles, K bytes loaded with it
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt <= 0;
         frame_o <= 1'b0;
         rx_k1_o <= 8'h00;
         rx_k2_o <= 8'h00;
      end else begin
         cnt <= (cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
         frame_o <= (cnt == FRAME_CYC - 1);
         if (cnt == FRAME_CYC - 1) begin
            rx_k1_o <= k1_i;
            rx_k2_o <= k2_i;
         end
      end
   end
endmodule : ast_ne_model
`default_nettype wire

/* File: tb/ast_switch_tester_tb.sv */
// Purpose: Self-checking bench of the switch tester
// Assumes: Frame model on far side
// Notes:   Durations checked to within one tick
`timescale 1ns/1ps
`default_nettype none
module ast_switch_tester_tb;
   import ast_pkg::*;
   typedef struct packed {ast_kcfg_t c; logic [7:0] k1; logic [7:0] k2;} ast_row_t;
   ast_row_t rows [7] = '{{3'h2, 1'b0, 1'b1, 4'h3, 4'h9, REQ_LOCKOUT, 8'hF9, 8'h32},
      {3'h6, 1'b1, 1'b1, 4'hF, 4'h0, REQ_FORCED, 8'hE0, 8'hFE}, {3'h0, 1'b0, 1'b0, 4'h1, 4'h5, REQ_SF_HIGH, 8'hD5, 8'h15},
      {3'h3, 1'b1, 1'b0, 4'h8, 4'hF, REQ_SF_LOW, 8'hCF, 8'h8D}, {3'h7, 1'b0, 1'b1, 4'h0, 4'h1, REQ_SD_HIGH, 8'hB1, 8'h07},
      {3'h1, 1'b1, 1'b1, 4'hA, 4'h7, REQ_MANUAL, 8'h87, 8'hA9}, {3'h4, 1'b0, 1'b0, 4'h5, 4'h2, REQ_NONE, 8'h02, 8'h55}};
   logic        ref_clk_i, rst_b_i = 1'b0, frame_i, irq_o;
   logic [15:0] evt_i = 16'h0;
   logic [7:0]  rx_k1_i, rx_k2_i, tx_k1_o, tx_k2_o, nk1 = 8'h00, nk2 = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   int          fails = 0, n_checks = 0, cycles = 0;
   ast_ne_model u_ast_ne_model (.ref_clk_i, .rst_b_i, .k1_i(nk1), .k2_i(nk2), .frame_o(frame_i), .rx_k1_o(rx_k1_i),
      .rx_k2_o(rx_k2_i));
   ast_switch_tester u_ast_switch_tester (.ref_clk_i, .rst_b_i, .evt_i, .frame_i, .rx_k1_i, .rx_k2_i, .tx_k1_o, .tx_k2_o,
      .irq_o, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
   ////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : wt
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ad = 1'b0;
      logic dd = 1'b0;
      @(posedge ref_clk_i);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_bready <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge ref_clk_i);
         if (s_axi_awvalid && s_axi_awready) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            dd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge ref_clk_i);
      chk(32'(s_axi_bresp), 32'(RESP_OKAY));
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
      @(posedge ref_clk_i);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      do @(posedge ref_clk_i); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge ref_clk_i);
      v = s_axi_rdata;
      q = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0]  q;
      rd(a, v, q);
      chk(v, e);
      chk(32'(q), 32'(RESP_OKAY));
   endtask : rc
   task automatic rng(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
      logic [31:0] v;
      logic [1:0]  q;
      rd(a, v, q);
      chk(32'(v >= lo && v <= hi), 32'h1);
   endtask : rng
   task automatic ev(input logic [15:0] b, input int us);
      @(posedge ref_clk_i);
      evt_i <= b;
      repeat (us * CYC_PER_TICK) @(posedge ref_clk_i);
      evt_i <= 16'h0;
   endtask : ev
   ////////////////////////////////////////////////////////////
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      wt(5);
      chk(32'({irq_o, tx_k1_o, tx_k2_o}), 32'h0);
      rst_b_i <= 1'b1;
      rd(8'h40, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      rd(8'h06, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      wr(OFS_CTRL, 32'h2);
      wr(OFS_KCFG, 32'(rows[0].c));
      wt(300);
      chk(32'({tx_k1_o, tx_k2_o}), 32'h0);
      foreach (rows[i]) begin
         wr(OFS_KCFG, 32'(rows[i].c));
         wr(OFS_APPLY, 32'h1);
         wt(300);
         chk(32'({tx_k1_o, tx_k2_o}), 32'({rows[i].k1, rows[i].k2}));
      end
      wr(OFS_IRQ_MASK, 32'h4);
      nk1 <= 8'hB3;
      nk2 <= 8'h4D;
      wt(300);
      rc(OFS_RXK, 32'h0000B34D);
      chk(32'(irq_o), 32'h1);
      wr(OFS_IRQ_STAT, 32'h4);
      wt(3);
      chk(32'(irq_o), 32'h0);
      wr(OFS_IRQ_MASK, 32'h0);
      nk1 <= 8'h5A;
      wt(300);
      rc(OFS_IRQ_STAT, 32'h4);
      chk(32'(irq_o), 32'h0);
      wr(OFS_CTRL, 32'h9);
      wr(OFS_REF, 32'h2);
      wr(OFS_THR, 32'd5);
      ev(16'h2, 10);
      wt(100);
      ev(16'h2, 4);
      wt(100);
      rc(OFS_COUNT, 32'd2);
      rng(OFS_MAX, 9, 11);
      rng(OFS_MIN, 3, 5);
      rng(OFS_AVG, 6, 8);
      rc(OFS_THR, 32'd5);
      rd(OFS_STATUS, d, r);
      chk(32'(d[ST_FAIL]), 32'h1);
      wr(OFS_LOG_IDX, 32'h1);
      wt(2);
      rng(OFS_LOG_DATA, 3, 5);
      wr(OFS_CTRL, 32'h9);
      wr(OFS_THR, 32'hFFFFFFFF);
      rc(OFS_THR, 32'(THR_MAX_PDH));
      ev(16'h2, 4);
      wt(100);
      rd(OFS_STATUS, d, r);
      chk(32'(d[ST_FAIL]), 32'h0);
      wr(OFS_CTRL, 32'hB);
      wr(OFS_THR, 32'hFFFFFFFF);
      rc(OFS_THR, 32'(THR_MAX_SDH));
      wr(OFS_REF, 32'h10000);
      wr(OFS_EFP, 32'd3);
      ev(16'hC000, 4);
      wt(800);
      rc(OFS_COUNT, 32'd0);
      ev(16'h20, 2);
      wt(125);
      ev(16'h20, 2);
      wt(1000);
      rc(OFS_COUNT, 32'd1);
      rng(OFS_MAX, 4, 6);
      for (int i = 0; i < 14; i++) begin
         ev(16'(1 << i), 1);
         wt(700);
      end
      rc(OFS_COUNT, 32'd15);
      wr(OFS_CTRL, 32'hF);
      wr(OFS_REF, 32'h1);
      ev(16'h1, 2);
      wt(800);
      rc(OFS_COUNT, 32'd0);
      end_sim();
   end
endmodule : ast_switch_tester_tb
`default_nettype wire
